// >>> design/fbmac_master.v
// Function
// - Send requests only while holding the token; otherwise stay silent.
// - On retention timeout pass the token to the next master.
// - Poll assigned slaves in fixed order each cycle, skipping failed ones, no software help.
// - Each slave goes parameterization, then configuration, then exchange.
// - Compare expected and actual configuration before admitting exchange.
// - In exchange send fresh outputs; reply carries latest inputs.
// - Resend configuration to a slave on request.
`timescale 1ns/1ps
`include "fbmac_map.vh"
module fbmac_master (
  input  wire                      i_core_clk,
  input  wire                      i_srst,
  input  wire                      i_token_in,
  input  wire [`FBMAC_NSLV-1:0]    i_slv_enable,
  input  wire [`FBMAC_CFG_W-1:0]   i_exp_cfg,
  input  wire [`FBMAC_DATA_W-1:0]  i_out_data,
  input  wire                      i_reconf_req,
  input  wire [`FBMAC_SIDX_W-1:0]  i_reconf_idx,
  input  wire                      i_req_ready,
  input  wire                      i_rsp_valid,
  input  wire [`FBMAC_CFG_W-1:0]   i_rsp_data,
  output reg                       o_req_valid,
  output reg  [`FBMAC_KIND_W-1:0]  o_req_kind,
  output reg  [`FBMAC_SIDX_W-1:0]  o_req_addr,
  output reg  [`FBMAC_DATA_W-1:0]  o_req_data,
  output reg                       o_token_held,
  output reg  [`FBMAC_NSLV-1:0]    o_cyclic_exchange_state,
  output reg  [`FBMAC_NSLV-1:0]    o_cfg_mismatch,
  output reg                       o_in_valid,
  output reg  [`FBMAC_SIDX_W-1:0]  o_in_addr,
  output reg  [`FBMAC_DATA_W-1:0]  o_in_data,
  output reg                       o_reconf_ack
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SEL  = 2'h1;
  localparam ST_SEND = 2'h2;
  localparam ST_WAIT = 2'h3;
  localparam integer TRT_FULL = `FBMAC_TRT_CYC;

  reg [1:0]                st_r;
  reg [`FBMAC_SIDX_W-1:0]  idx_r;
  reg [`FBMAC_TMR_W-1:0]   tmr_r;
  reg [`FBMAC_KIND_W-1:0]  kind_r;
  reg                      reconf_pend_r;
  reg [`FBMAC_SIDX_W-1:0]  reconf_idx_r;
  reg [`FBMAC_PH_W-1:0]    ph_r [0:`FBMAC_NSLV-1];
  reg                      token_pass_r;
  reg  [`FBMAC_SLOT_W-1:0] slot_r;
  wire                     reconf_take;
  wire [`FBMAC_PH_W-1:0]   cur_ph;
  wire                     tmo;
  wire                     b_ready;
  wire                     b_valid;
  wire [`FBMAC_KIND_W+`FBMAC_SIDX_W+`FBMAC_DATA_W-1:0] b_out;
  reg  [`FBMAC_KIND_W+`FBMAC_SIDX_W+`FBMAC_DATA_W-1:0] b_in;
  reg                      b_push;

  assign cur_ph = ph_r[idx_r];
  assign tmo    = (tmr_r == `FBMAC_TMR_W'h0);
  // Pending reconfiguration is taken in one cycle only, so one ack per ask
  assign reconf_take = (st_r == ST_SEL) && !tmo && reconf_pend_r && b_ready;

  // Request path buffered so a stalled link drops nothing
  fbmac_buf2 #(
    .W(`FBMAC_KIND_W+`FBMAC_SIDX_W+`FBMAC_DATA_W)
  ) u_buf (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_data     (b_in),
    .i_valid    (b_push),
    .o_ready    (b_ready),
    .o_data     (b_out),
    .o_valid    (b_valid),
    .i_ready    (i_req_ready && o_token_held)
  );

  // Register the link outputs; only driven while holding the token
  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_req_valid <= 1'b0;
      o_req_kind  <= `FBMAC_KIND_PARAM;
      o_req_addr  <= {`FBMAC_SIDX_W{1'b0}};
      o_req_data  <= {`FBMAC_DATA_W{1'b0}};
    end
    else if (!o_req_valid || i_req_ready)
    begin
      o_req_valid <= b_valid && o_token_held && i_req_ready;
      o_req_kind  <= b_out[`FBMAC_KIND_W+`FBMAC_SIDX_W+`FBMAC_DATA_W-1:
                           `FBMAC_SIDX_W+`FBMAC_DATA_W];
      o_req_addr  <= b_out[`FBMAC_SIDX_W+`FBMAC_DATA_W-1:`FBMAC_DATA_W];
      o_req_data  <= b_out[`FBMAC_DATA_W-1:0];
    end
  end

  // Per-slave phase bits exported from the phase table
  genvar g;
  generate
    for (g = 0; g < `FBMAC_NSLV; g = g + 1)
    begin : g_flag
      always @(posedge i_core_clk)
      begin
        if (i_srst)
        begin
          o_cyclic_exchange_state[g] <= 1'b0;
          o_cfg_mismatch[g]          <= 1'b0;
        end
        else
        begin
          o_cyclic_exchange_state[g] <= (ph_r[g] == `FBMAC_PH_XCHG)
                                        && i_slv_enable[g];
          o_cfg_mismatch[g]          <= (ph_r[g] == `FBMAC_PH_FAIL);
        end
      end
    end
  endgenerate

  // Request pending to reconfigure one slave; set wins over clear
  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      reconf_pend_r <= 1'b0;
      reconf_idx_r  <= {`FBMAC_SIDX_W{1'b0}};
    end
    else if (i_reconf_req)
    begin
      reconf_pend_r <= 1'b1;
      reconf_idx_r  <= i_reconf_idx;
    end
    else if (reconf_take)
      reconf_pend_r <= 1'b0;
  end

  // Main polling sequencer
  integer k;
  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      st_r         <= ST_IDLE;
      idx_r        <= {`FBMAC_SIDX_W{1'b0}};
      tmr_r        <= `FBMAC_TMR_W'h0;
      kind_r       <= `FBMAC_KIND_PARAM;
      o_token_held <= 1'b0;
      token_pass_r <= 1'b0;
      slot_r       <= {`FBMAC_SLOT_W{1'b0}};
      o_in_valid   <= 1'b0;
      o_in_addr    <= {`FBMAC_SIDX_W{1'b0}};
      o_in_data    <= {`FBMAC_DATA_W{1'b0}};
      o_reconf_ack <= 1'b0;
      b_push       <= 1'b0;
      b_in         <= {(`FBMAC_KIND_W+`FBMAC_SIDX_W+`FBMAC_DATA_W){1'b0}};
      for (k = 0; k < `FBMAC_NSLV; k = k + 1)
        ph_r[k] <= `FBMAC_PH_PARAM;
    end
    else
    begin
      o_in_valid   <= 1'b0;
      o_reconf_ack <= 1'b0;
      b_push       <= 1'b0;
      if (tmr_r != `FBMAC_TMR_W'h0)
        tmr_r <= tmr_r - `FBMAC_TMR_W'h1;
      // Excluded slaves drop back to start so re-entry is re-checked
      for (k = 0; k < `FBMAC_NSLV; k = k + 1)
        if (!i_slv_enable[k])
          ph_r[k] <= `FBMAC_PH_PARAM;
      case (st_r)
        ST_IDLE:
        begin
          token_pass_r <= 1'b0;
          if (i_token_in && !token_pass_r)
          begin
            o_token_held <= 1'b1;
            tmr_r        <= TRT_FULL[`FBMAC_TMR_W-1:0];
            st_r         <= ST_SEL;
          end
        end
        ST_SEL:
        begin
          if (tmo && b_ready && !b_valid)
          begin
            // Retention over: send the token frame, then go silent
            b_in         <= {`FBMAC_KIND_TOKEN, {`FBMAC_SIDX_W{1'b0}},
                             {`FBMAC_DATA_W{1'b0}}};
            b_push       <= 1'b1;
            st_r         <= ST_SEND;
            kind_r       <= `FBMAC_KIND_TOKEN;
          end
          else if (reconf_take)
          begin
            idx_r        <= reconf_idx_r;
            ph_r[reconf_idx_r] <= `FBMAC_PH_CFG;
            o_reconf_ack <= 1'b1;
          end
          else if (!tmo && !i_slv_enable[idx_r])
            idx_r <= idx_r + `FBMAC_SIDX_W'h1;
          else if (!tmo && cur_ph == `FBMAC_PH_FAIL)
            idx_r <= idx_r + `FBMAC_SIDX_W'h1;
          else if (!tmo && b_ready)
          begin
            case (cur_ph)
              `FBMAC_PH_PARAM: kind_r <= `FBMAC_KIND_PARAM;
              `FBMAC_PH_CFG:   kind_r <= `FBMAC_KIND_CFG;
              default:         kind_r <= `FBMAC_KIND_DATA;
            endcase
            b_in   <= {(cur_ph == `FBMAC_PH_PARAM) ? `FBMAC_KIND_PARAM :
                       (cur_ph == `FBMAC_PH_CFG) ? `FBMAC_KIND_CFG :
                       `FBMAC_KIND_DATA, idx_r,
                       (cur_ph == `FBMAC_PH_CFG) ? i_exp_cfg :
                       i_out_data};
            b_push <= 1'b1;
            st_r   <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          // Token frame needs no answer; others await the slave reply
          if (kind_r == `FBMAC_KIND_TOKEN)
          begin
            // Push lands one cycle late; wait until the frame has left
            if (!b_push && !b_valid && !o_req_valid)
            begin
              o_token_held <= 1'b0;
              token_pass_r <= 1'b1;
              st_r         <= ST_IDLE;
            end
          end
          else
          begin
            slot_r <= `FBMAC_SLOT_CYC;
            st_r   <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (i_rsp_valid)
          begin
            case (kind_r)
              `FBMAC_KIND_PARAM: ph_r[idx_r] <= `FBMAC_PH_CFG;
              `FBMAC_KIND_CFG:
                ph_r[idx_r] <= (i_rsp_data == i_exp_cfg) ?
                               `FBMAC_PH_XCHG : `FBMAC_PH_FAIL;
              default:
              begin
                o_in_valid <= 1'b1;
                o_in_addr  <= idx_r;
                o_in_data  <= i_rsp_data;
              end
            endcase
            idx_r <= idx_r + `FBMAC_SIDX_W'h1;
            st_r  <= ST_SEL;
          end
          // A silent slave ends the wait after the slot, never a late reply
          else if (slot_r == `FBMAC_SLOT_W'h0)
            st_r <= ST_SEL;
          else if (!o_req_valid && !b_valid)
            slot_r <= slot_r - `FBMAC_SLOT_W'h1;
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // fbmac_master

// >>> inc/fbmac_map.vh
`ifndef FBMAC_MAP_VH
`define FBMAC_MAP_VH
// Slave table size and data widths
`define FBMAC_NSLV        8
`define FBMAC_SIDX_W      3
`define FBMAC_DATA_W      16
`define FBMAC_CFG_W       16
// Request kinds on the link
`define FBMAC_KIND_W      2
`define FBMAC_KIND_PARAM  2'h0
`define FBMAC_KIND_CFG    2'h1
`define FBMAC_KIND_DATA   2'h2
`define FBMAC_KIND_TOKEN  2'h3
// Per-slave phases
`define FBMAC_PH_W        2
`define FBMAC_PH_PARAM    2'h0
`define FBMAC_PH_CFG      2'h1
`define FBMAC_PH_XCHG     2'h2
`define FBMAC_PH_FAIL     2'h3
// Token retention time in us, and cycle count at 50 MHz
`define FBMAC_TRT_US      100
`define FBMAC_CLK_MHZ     50
`define FBMAC_TRT_CYC     (`FBMAC_TRT_US * `FBMAC_CLK_MHZ)
`define FBMAC_TMR_W       16
// Reply wait once a request has left the link, in cycles
`define FBMAC_SLOT_CYC    8'h20
`define FBMAC_SLOT_W      8
`endif

// >>> design/fbmac_buf2.v
`timescale 1ns/1ps
// Two-entry skid buffer; a stall downstream loses no word
module fbmac_buf2 #(
  parameter W = 16
) (
  input  wire         i_core_clk,
  input  wire         i_srst,
  input  wire [W-1:0] i_data,
  input  wire         i_valid,
  output wire         o_ready,
  output wire [W-1:0] o_data,
  output wire         o_valid,
  input  wire         i_ready
);
  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;

  assign push    = i_valid && (cnt_r != 2'h2);
  assign pop     = (cnt_r != 2'h0) && i_ready;
  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data  = mem_r[rp_r];

  // Pointers and fill count
  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= i_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule // fbmac_buf2

// >>> tb/fbmac_monitor.sv
`timescale 1ns/1ps
`include "fbmac_map.vh"
module fbmac_monitor (
  input wire                     i_core_clk,
  input wire                     i_srst,
  input wire [`FBMAC_NSLV-1:0]   i_slv_enable,
  input wire [`FBMAC_CFG_W-1:0]  i_exp_cfg,
  input wire [`FBMAC_DATA_W-1:0] i_out_data,
  input wire                     i_req_ready,
  input wire                     i_rsp_valid,
  input wire                     o_req_valid,
  input wire [`FBMAC_KIND_W-1:0] o_req_kind,
  input wire [`FBMAC_SIDX_W-1:0] o_req_addr,
  input wire [`FBMAC_DATA_W-1:0] o_req_data,
  input wire                     o_token_held,
  input wire [`FBMAC_NSLV-1:0]   o_cyclic_exchange_state,
  input wire [`FBMAC_NSLV-1:0]   o_cfg_mismatch,
  input wire                     o_in_valid,
  input wire                     o_reconf_ack
);
  localparam int TRT_LIM = `FBMAC_TRT_CYC + 64;
  reg [15:0] held_cnt_r;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Ownership length; margin covers a request stalled at the end
  always @(posedge i_core_clk)
    held_cnt_r <= (i_srst || !o_token_held) ? 16'h0000 : held_cnt_r + 16'h0001;
  AST_SILENT: assert property (
    o_req_valid && o_req_kind != `FBMAC_KIND_TOKEN |-> o_token_held)
    else $error("slave request without token");
  AST_TRT: assert property (
    held_cnt_r <= TRT_LIM) else $error("token kept too long");
  AST_HOLD: assert property (
    o_req_valid && !i_req_ready |=> o_req_valid && $stable(o_req_addr)
    && $stable(o_req_kind)) else $error("request dropped before ready");
  AST_SKIP: assert property (
    $rose(o_req_valid) && o_req_kind != `FBMAC_KIND_TOKEN
    && $stable(i_slv_enable) |-> i_slv_enable[o_req_addr])
    else $error("excluded slave polled");
  AST_XCHG: assert property (
    o_req_valid && o_req_kind == `FBMAC_KIND_DATA
    |-> o_cyclic_exchange_state[o_req_addr])
    else $error("data sent before exchange state");
  AST_CFG_WORD: assert property (
    o_req_valid && o_req_kind == `FBMAC_KIND_CFG |-> o_req_data == i_exp_cfg)
    else $error("config word differs");
  AST_OUT: assert property (
    o_req_valid && o_req_kind == `FBMAC_KIND_DATA |-> o_req_data == i_out_data)
    else $error("output data not fresh");
  AST_EXCL: assert property (
    (o_cfg_mismatch & o_cyclic_exchange_state) == 0)
    else $error("mismatched slave in exchange");
  AST_IN: assert property (
    o_in_valid |-> $past(i_rsp_valid) ##1 !o_in_valid)
    else $error("input pulse without reply");
  AST_ACK1: assert property (
    o_reconf_ack |=> !o_reconf_ack) else $error("reconfig taken twice");
  COV_PASS: cover property ($fell(o_token_held));
  COV_DATA: cover property (o_req_valid && i_req_ready
    && o_req_kind == `FBMAC_KIND_DATA);
  COV_MISM: cover property (|o_cfg_mismatch);
  COV_RECONF: cover property (o_reconf_ack);
endmodule // fbmac_monitor

// >>> tb/fbmac_slv_model.sv
`timescale 1ns/1ps
`include "fbmac_map.vh"
module fbmac_slv_model (
  input  wire                     i_core_clk,
  input  wire                     i_srst,
  input  wire                     i_slow,
  input  wire [`FBMAC_NSLV-1:0]   i_bad_cfg,
  input  wire [`FBMAC_CFG_W-1:0]  i_act_cfg,
  input  wire                     i_req_valid,
  input  wire [`FBMAC_KIND_W-1:0] i_req_kind,
  input  wire [`FBMAC_SIDX_W-1:0] i_req_addr,
  output reg                      o_req_ready,
  output reg                      o_rsp_valid,
  output reg  [`FBMAC_DATA_W-1:0] o_rsp_data
);
  reg [7:0]  seq_r [0:7];
  reg        pend_r;
  reg [2:0]  dly_r;
  reg [15:0] word_r;
  integer    k;
  // Reply only to a taken request; idle data toggles so stale words show
  always @(posedge i_core_clk)
  begin
    o_rsp_valid <= 1'b0;
    o_rsp_data  <= ~o_rsp_data;
    o_req_ready <= i_slow ? 1'($urandom_range(0, 1)) : 1'b1;
    if (i_srst)
    begin
      pend_r     <= 1'b0;
      o_rsp_data <= 16'h5A5A;
      for (k = 0; k < 8; k = k + 1)
        seq_r[k] <= 8'h00;
    end
    else if (pend_r)
    begin
      if (dly_r == 3'h0)
      begin
        o_rsp_valid <= 1'b1;
        o_rsp_data  <= word_r;
        pend_r      <= 1'b0;
      end
      else
        dly_r <= dly_r - 3'h1;
    end
    else if (i_req_valid && o_req_ready && i_req_kind != `FBMAC_KIND_TOKEN)
    begin
      pend_r <= 1'b1;
      dly_r  <= i_slow ? 3'($urandom_range(0, 5)) : 3'h0;
      word_r <= 16'h0000;
      if (i_req_kind == `FBMAC_KIND_CFG)
        word_r <= i_bad_cfg[i_req_addr] ? ~i_act_cfg : i_act_cfg;
      if (i_req_kind == `FBMAC_KIND_DATA)
      begin
        word_r <= {i_req_addr, 5'h00, seq_r[i_req_addr]};
        seq_r[i_req_addr] <= seq_r[i_req_addr] + 8'h01;
      end
    end
  end
endmodule // fbmac_slv_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "fbmac_map.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb;
  reg         i_core_clk = 0, i_srst = 1, tok = 0, rcf = 0, slow = 0;
  reg  [7:0]  en = 0, bad = 0;
  reg  [15:0] cfg = 0, outd = 0;
  wire        req_v, rdy, rsp_v, held, in_v, ack;
  wire [1:0]  kind;
  wire [2:0]  addr, in_a;
  wire [15:0] req_d, rsp_d, in_d;
  wire [7:0]  xchg, mism;
  reg  [1:0]  ph [0:7];
  reg  [7:0]  seq [0:7];
  reg  [2:0]  prev, ridx = 0;
  reg         prev_ok = 0, tok_seen = 0;
  integer     fail_count = 0, num_checks = 0, cyc = 0, t, w, k;
  integer     ack_cnt = 0;
  fbmac_master u_dut (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_token_in(tok), .i_slv_enable(en), .i_exp_cfg(cfg), .i_out_data(outd),
    .i_reconf_req(rcf), .i_reconf_idx(ridx), .i_req_ready(rdy),
    .i_rsp_valid(rsp_v), .i_rsp_data(rsp_d), .o_req_valid(req_v),
    .o_req_kind(kind), .o_req_addr(addr), .o_req_data(req_d),
    .o_token_held(held), .o_cyclic_exchange_state(xchg),
    .o_cfg_mismatch(mism), .o_in_valid(in_v), .o_in_addr(in_a),
    .o_in_data(in_d), .o_reconf_ack(ack));
  fbmac_slv_model u_slv (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_slow(slow), .i_bad_cfg(bad), .i_act_cfg(cfg), .i_req_valid(req_v),
    .i_req_kind(kind), .i_req_addr(addr), .o_req_ready(rdy),
    .o_rsp_valid(rsp_v), .o_rsp_data(rsp_d));
  always #10 i_core_clk = ~i_core_clk;
  task print_verdict;
  begin
    $display("Compares %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // Next enabled, not failed slave after p, wrapping; expected poll order
  function [2:0] next_en(input [2:0] p);
    integer i;
  begin
    next_en = p;
    for (i = 7; i >= 1; i = i - 1)
      if (en[3'(p + i)] && ph[3'(p + i)] != 2'h3)
        next_en = 3'(p + i);
  end
  endfunction
  // Hang guard, well above six token rounds
  always @(posedge i_core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      print_verdict;
    end
  end
  // Follow every taken request and every delivered input word
  always @(posedge i_core_clk)
  begin
    if (!i_srst && req_v && rdy && kind == `FBMAC_KIND_TOKEN)
    begin
      tok_seen = 1;
      prev_ok = 0;
    end
    else if (!i_srst && req_v && rdy)
    begin
      `CHK("slave_en", 1'b1, en[addr])
      `CHK("req_kind", ph[addr], kind)
      if (prev_ok && addr != prev)
        `CHK("poll_next", next_en(prev), addr)
      if (ph[addr] == 2'h1)
        ph[addr] = bad[addr] ? 2'h3 : 2'h2;
      else if (ph[addr] == 2'h0)
        ph[addr] = 2'h1;
      prev = addr;
      prev_ok = 1;
    end
    if (!i_srst && in_v)
    begin
      `CHK("in_data", {in_a, 5'h00, seq[in_a]}, in_d)
      seq[in_a] = seq[in_a] + 8'h01;
    end
    if (!i_srst && ack)
    begin
      ph[ridx] = 2'h1;
      prev_ok = 0;
      ack_cnt = ack_cnt + 1;
    end
  end
  initial
  begin
    k = $urandom(32'hDEB98446);
    for (k = 0; k < 8; k = k + 1)
    begin
      ph[k] = 2'h0;
      seq[k] = 8'h00;
    end
    en  <= 8'($urandom) & 8'hEF | 8'h01; // Slave 4 always left out
    bad <= 8'($urandom) & 8'hFE; // Slave 0 always good
    cfg <= 16'($urandom);
    repeat (10) @(posedge i_core_clk);
    i_srst <= 1'b0;
    for (t = 0; t < 6; t = t + 1)
    begin
      slow <= t[0];
      outd <= 16'($urandom);
      if (t == 4)
      begin
        rcf  <= 1'b1; // One-cycle ask, held pending until the token comes
        ridx <= 3'($urandom);
      end
      @(posedge i_core_clk);
      tok <= 1'b1;
      rcf <= 1'b0;
      tok_seen = 0;
      @(posedge i_core_clk);
      tok <= 1'b0;
      for (w = 0; w < 6000 && (held || w < 8); w = w + 1)
      begin
        @(posedge i_core_clk);
      end
      `CHK("token_pass", 1'b1, tok_seen)
      `CHK("token_free", 1'b0, held)
    end
    `CHK("mismatch", bad & en, mism)
    `CHK("exchange", en & ~bad, xchg)
    `CHK("reconf_ack", 1, ack_cnt)
    print_verdict;
  end
endmodule // tb
bind fbmac_master fbmac_monitor u_mon (.i_core_clk(i_core_clk),
  .i_srst(i_srst), .i_slv_enable(i_slv_enable), .i_exp_cfg(i_exp_cfg),
  .i_out_data(i_out_data), .i_req_ready(i_req_ready),
  .i_rsp_valid(i_rsp_valid), .o_req_valid(o_req_valid),
  .o_req_kind(o_req_kind), .o_req_addr(o_req_addr),
  .o_req_data(o_req_data), .o_token_held(o_token_held),
  .o_cyclic_exchange_state(o_cyclic_exchange_state),
  .o_cfg_mismatch(o_cfg_mismatch), .o_in_valid(o_in_valid),
  .o_reconf_ack(o_reconf_ack));
